// File: src/bscm_pkg.sv
package bscm_pkg;

    // ****************************************************************
    // opcode patterns
    // ****************************************************************
    localparam logic [3:0]  OP_SKIP_CLR     = 4'hB;        // bit test, skip when clear
    localparam logic [3:0]  OP_SKIP_SET     = 4'hA;        // bit test, skip when set
    localparam logic [15:0] OP_CALL_WORKING_REGISTER    = 16'h0014;    // call through working register
    localparam logic [8:0]  OP_MOVE_IDX     = 9'h1D6;      // 1110_1011_0 prefix of indexed move
    localparam logic [3:0]  OP_SECOND_WORD  = 4'hF;        // prefix of any second word

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BIT_IDX_LSB  = 9;     // three-bit bit index
    localparam int ACCESS_POS   = 8;     // access select bit
    localparam int OFFSET_W     = 7;     // unsigned offset width
    localparam int DEST_W       = 12;    // destination field width
    localparam int ADDR_W       = 12;    // data address width
    localparam int PC_W         = 21;    // program counter width

    // ****************************************************************
    // special addresses
    // ****************************************************************
    localparam logic [ADDR_W-1:0] ADDR_TOP_LOW  = 12'hFFD;  // stack top low byte
    localparam logic [ADDR_W-1:0] ADDR_TOP_HIGH = 12'hFFE;  // stack top high byte
    localparam logic [ADDR_W-1:0] ADDR_TOP_UPP  = 12'hFFF;  // stack top upper byte
    localparam logic [ADDR_W-1:0] ADDR_PC_LOW   = 12'hFF9;  // counter low byte
    localparam logic [ADDR_W-1:0] ADDR_IND_LO   = 12'hFDB;  // lowest indirect register
    localparam logic [ADDR_W-1:0] ADDR_IND_HI   = 12'hFEF;  // highest indirect register
    localparam logic [7:0]        READ_ZERO     = 8'h00;    // value of indirect source read
    localparam logic [7:0]        ACCESS_SPLIT  = 8'h60;    // access bank low/high split
    localparam logic [3:0]        ACCESS_HI_BANK = 4'hF;    // bank of access upper half
    localparam logic [PC_W-1:0]   PC_STEP       = 21'h000002; // return offset
    localparam logic [PC_W-1:0]   PC_RESET      = 21'h000000; // counter after reset

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic              we;      // write strobe
        logic [ADDR_W-1:0] addr;    // data address
        logic [7:0]        data;    // write data
    } bscm_wr_t;

    typedef struct packed {
        logic            push;      // push pulse
        logic [PC_W-1:0] addr;      // pushed return address
    } bscm_push_t;

    typedef enum logic [1:0] {
        OPC_OTHER,
        OPC_SKIP,
        OPC_CALL_VIA_WORKING_REGISTER,
        OPC_MOVE
    } bscm_opc_t;

endpackage

// File: src/bscm_decode.sv
// ****************************************************************
// opcode recognition and bit-test address formation
// ****************************************************************
module bscm_decode (
    input  wire logic [15:0]                   instr_i,
    input  wire logic [3:0]                    bank_i,
    output bscm_pkg::bscm_opc_t                opc_o,
    output logic                               skip_on_set_o,
    output logic [2:0]                         bit_idx_o,
    output logic [bscm_pkg::ADDR_W-1:0]        file_addr_o,
    output logic                               two_word_o
);
    // first word of the indexed move; shared by class and length decode
    function automatic logic is_move_first(input logic [15:0] w);
        return (w[15:7] == bscm_pkg::OP_MOVE_IDX);
    endfunction

    // fixed decode of one word
    always_comb begin
        opc_o         = bscm_pkg::OPC_OTHER;
        skip_on_set_o = 1'b0;
        if (instr_i[15:12] == bscm_pkg::OP_SKIP_CLR) begin                    // [RQ1]
            opc_o = bscm_pkg::OPC_SKIP;
        end else if (instr_i[15:12] == bscm_pkg::OP_SKIP_SET) begin           // [RQ2]
            opc_o         = bscm_pkg::OPC_SKIP;
            skip_on_set_o = 1'b1;
        end else if (instr_i == bscm_pkg::OP_CALL_WORKING_REGISTER) begin
            opc_o = bscm_pkg::OPC_CALL_VIA_WORKING_REGISTER;
        end else if (is_move_first(instr_i)) begin
            opc_o = bscm_pkg::OPC_MOVE;
        end
    end

    // bit index, access select, file address fields
    assign bit_idx_o = instr_i[bscm_pkg::BIT_IDX_LSB +: 3];                  // [RQ14]

    // access bank when select is clear, else bank register
    always_comb begin
        if (instr_i[bscm_pkg::ACCESS_POS]) begin                              // [RQ5]
            file_addr_o = {bank_i, instr_i[7:0]};
        end else if (instr_i[7:0] < bscm_pkg::ACCESS_SPLIT) begin
            file_addr_o = {4'h0, instr_i[7:0]};
        end else begin
            file_addr_o = {bscm_pkg::ACCESS_HI_BANK, instr_i[7:0]};
        end
    end

    // only the indexed move is two-word in this subset
    assign two_word_o = is_move_first(instr_i);                              // [RQ4]
endmodule // bscm_decode

// File: src/bscm_core.sv
// Notes on behaviour
// RQ1 - prefix 1011 skips next when bit clear
// RQ2 - prefix 1010 skips next when bit set
// RQ3 - met skip turns next word into no-op
// RQ4 - two-word skipped instruction costs two no-ops
// RQ5 - access bit picks access bank or bank register
// RQ6 - call pushes PC+2, loads counter from latches
// RQ7 - call spends second cycle as no-op
// RQ8 - call leaves working, status, bank untouched
// RQ9 - move source is pointer plus 7-bit offset
// RQ10 - move destination is 12-bit second-word field
// RQ11 - program never targets counter low or stack top
// RQ12 - indirect register source reads as zero
// RQ13 - move takes two words, two cycles
// RQ14 - bit index, access, file address field layout
module bscm_core (
    input  wire logic                          core_clk_i,
    input  wire logic                          srst_i,
    input  wire logic                          instr_valid_i,  // one fetched word per cycle
    input  wire logic [15:0]                   instr_i,
    input  wire logic [7:0]                    rd_data_i,      // data read at rd_addr_o
    input  wire logic [7:0]                    working_register_i,
    input  wire logic [3:0]                    bank_select_register_i,
    input  wire logic [bscm_pkg::ADDR_W-1:0]   second_indirect_pointer_i,
    input  wire logic [7:0]                    counter_high_latch_i,
    input  wire logic [4:0]                    counter_upper_latch_i,
    input  wire logic [bscm_pkg::PC_W-1:0]     pc_i,           // address of current word
    output logic [bscm_pkg::ADDR_W-1:0]        rd_addr_o,
    output bscm_pkg::bscm_wr_t                 wr_o,
    output bscm_pkg::bscm_push_t               push_o,
    output logic                               pc_load_o,
    output logic [bscm_pkg::PC_W-1:0]          pc_new_o,
    output logic                               nop_o           // word is discarded
);
    // ****************************************************************
    // decode
    // ****************************************************************
    bscm_pkg::bscm_opc_t       opc;                  // class of current word
    logic                      on_set;               // skip polarity
    logic [2:0]                bit_idx;              // tested bit
    logic [bscm_pkg::ADDR_W-1:0] f_addr;             // bit-test address
    logic                      two_word;             // current word is a two-word opcode

    bscm_decode u_dec (
        .instr_i       (instr_i),
        .bank_i        (bank_select_register_i),
        .opc_o         (opc),
        .skip_on_set_o (on_set),
        .bit_idx_o     (bit_idx),
        .file_addr_o   (f_addr),
        .two_word_o    (two_word)
    );

    typedef enum {ST_EXEC, ST_SKIP, ST_SKIP2, ST_CALL_NOP, ST_MOVE2} bscm_st_t;
    bscm_st_t state_reg;                             // execution phase
    bscm_st_t state_next;

    logic [bscm_pkg::ADDR_W-1:0] src_addr;           // computed move source
    logic                        src_ind;            // source is an indirect register
    logic [7:0]                  src_val_reg;        // latched source data
    logic                        skip_hit;           // skip condition met
    logic                        go;                 // new word executes

    assign go = instr_valid_i && (state_reg == ST_EXEC);

    // pointer plus unsigned offset, wraps in the 4K space
    assign src_addr = second_indirect_pointer_i
                    + {5'h00, instr_i[bscm_pkg::OFFSET_W-1:0]};              // [RQ9]
    assign src_ind  = (src_addr >= bscm_pkg::ADDR_IND_LO)
                    && (src_addr <= bscm_pkg::ADDR_IND_HI);
    // bit picked from data read this cycle
    assign skip_hit = (rd_data_i[bit_idx] == on_set);                       // [RQ1] [RQ2]

    // ****************************************************************
    // sequencing
    // ****************************************************************
    // next phase; skipped words are consumed one per valid cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_EXEC: begin
                if (go && opc == bscm_pkg::OPC_SKIP && skip_hit) begin
                    state_next = ST_SKIP;                                    // [RQ3]
                end else if (go && opc == bscm_pkg::OPC_CALL_VIA_WORKING_REGISTER) begin
                    state_next = ST_CALL_NOP;                                // [RQ7]
                end else if (go && opc == bscm_pkg::OPC_MOVE) begin
                    state_next = ST_MOVE2;                                   // [RQ13]
                end
            end
            ST_SKIP: begin
                if (instr_valid_i) begin
                    state_next = two_word ? ST_SKIP2 : ST_EXEC;              // [RQ4]
                end
            end
            ST_SKIP2: begin
                if (instr_valid_i) begin
                    state_next = ST_EXEC;
                end
            end
            ST_CALL_NOP: begin
                if (instr_valid_i) begin
                    state_next = ST_EXEC;
                end
            end
            ST_MOVE2: begin
                if (instr_valid_i) begin
                    state_next = ST_EXEC;
                end
            end
            default: state_next = ST_EXEC;
        endcase
    end

    // phase register
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_reg <= ST_EXEC;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // data path
    // ****************************************************************
    // read address: bit-test file or move source, registered for the memory
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rd_addr_o <= '0;
        end else if (state_next == ST_EXEC || state_reg == ST_EXEC) begin
            rd_addr_o <= (opc == bscm_pkg::OPC_MOVE) ? src_addr : f_addr;
        end
    end

    // source captured in first move cycle; indirect reads give zero
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            src_val_reg <= bscm_pkg::READ_ZERO;
        end else if (go && opc == bscm_pkg::OPC_MOVE) begin
            src_val_reg <= src_ind ? bscm_pkg::READ_ZERO : rd_data_i;        // [RQ12]
        end
    end

    // destination write in the second move cycle
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_o <= '0;
        end else begin
            wr_o.we   <= (state_reg == ST_MOVE2) && instr_valid_i;           // [RQ13]
            wr_o.addr <= instr_i[bscm_pkg::DEST_W-1:0];                      // [RQ10]
            wr_o.data <= src_val_reg;
        end
    end

    // call: push return address and load counter from latches
    // working, status and bank are never driven here
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            push_o    <= '0;
            pc_load_o <= 1'b0;
            pc_new_o  <= bscm_pkg::PC_RESET;
        end else begin
            push_o.push <= go && opc == bscm_pkg::OPC_CALL_VIA_WORKING_REGISTER;                 // [RQ6] [RQ8]
            push_o.addr <= pc_i + bscm_pkg::PC_STEP;
            pc_load_o   <= go && opc == bscm_pkg::OPC_CALL_VIA_WORKING_REGISTER;
            pc_new_o    <= {counter_upper_latch_i, counter_high_latch_i,
                            working_register_i};                             // [RQ6]
        end
    end

    // discard marker for words that execute as no-ops
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            nop_o <= 1'b0;
        end else begin
            // second move word does real work (the write), so it is never a no-op
            nop_o <= instr_valid_i && state_reg != ST_EXEC
                     && state_reg != ST_MOVE2;                               // [RQ3] [RQ7] [RQ13]
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence call_seen_s;
        go && opc == bscm_pkg::OPC_CALL_VIA_WORKING_REGISTER;
    endsequence

    call_push_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ6]
        call_seen_s |=> push_o.push && pc_load_o && push_o.addr == $past(pc_i) + 21'h2)
        else $error("call did not push return address");

    call_nop_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ7]
        call_seen_s ##1 instr_valid_i |=> nop_o)
        else $error("call second cycle not a no-op");

    skip_once_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ3]
        go && opc == bscm_pkg::OPC_SKIP && skip_hit ##1 instr_valid_i && !two_word
        |=> nop_o ##0 state_reg == ST_EXEC)
        else $error("skip of one word wrong");

    skip_two_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ4]
        state_reg == ST_SKIP && instr_valid_i && two_word |=> state_reg == ST_SKIP2)
        else $error("two-word skip not extended");

    no_skip_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ1]
        go && opc == bscm_pkg::OPC_SKIP && !skip_hit |=> state_reg == ST_EXEC)
        else $error("skip taken without condition");

    move_write_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ13]
        go && opc == bscm_pkg::OPC_MOVE ##1 instr_valid_i |=> wr_o.we)
        else $error("move did not write in second cycle");

    ind_zero_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ12]
        go && opc == bscm_pkg::OPC_MOVE && src_ind |=> src_val_reg == 8'h00)
        else $error("indirect source not zero");

    call_keep_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ6]
        push_o.push |-> pc_new_o[7:0] == $past(working_register_i))
        else $error("counter low not from working register");

    // first word of an indexed move taken for execution
    sequence move_first_s;
        go && opc == bscm_pkg::OPC_MOVE;
    endsequence

    move_not_nop_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ13]
        move_first_s ##1 instr_valid_i |=> !nop_o)
        else $error("move second word flagged as no-op");

    skip_tail_a: assert property (@(posedge core_clk_i) disable iff (srst_i) // [RQ4]
        state_reg == ST_SKIP2 && instr_valid_i |=> nop_o && state_reg == ST_EXEC)
        else $error("two-word skip tail wrong");
endmodule // bscm_core

// File: testbench/bit_skip_call_move_exec_bench.sv
module bit_skip_call_move_exec_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // signals at the core ports
    // ****************************************************************
    logic                        core_clk_i;            // 250 MHz core clock
    logic                        srst_i;                // sync reset, active high
    logic                        instr_valid_i;
    logic [15:0]                 instr_i;
    logic [7:0]                  rd_data_i;             // modelled memory read data
    logic [7:0]                  working_register_i;
    logic [3:0]                  bank_select_register_i;
    logic [11:0]                 second_indirect_pointer_i;
    logic [7:0]                  counter_high_latch_i;
    logic [4:0]                  counter_upper_latch_i;
    logic [20:0]                 pc_i;
    logic [11:0]                 rd_addr_o;
    bscm_pkg::bscm_wr_t          wr_o;
    bscm_pkg::bscm_push_t        push_o;
    logic                        pc_load_o;
    logic [20:0]                 pc_new_o;
    logic                        nop_o;
    // ****************************************************************
    // notes of expected results: {cycle, value}
    // ****************************************************************
    logic [95:0]                 q_wr[$];
    logic [95:0]                 q_push[$];
    logic [95:0]                 q_nop[$];
    logic [95:0]                 q_rd[$];
    int                          cyc = 0;               // clock cycle counter
    int                          fail_count = 0;
    int                          check_count = 0;
    int                          seed = 61;

    bscm_core dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .rd_data_i(rd_data_i), .working_register_i(working_register_i),
        .bank_select_register_i(bank_select_register_i),
        .second_indirect_pointer_i(second_indirect_pointer_i),
        .counter_high_latch_i(counter_high_latch_i), .counter_upper_latch_i(counter_upper_latch_i),
        .pc_i(pc_i), .rd_addr_o(rd_addr_o), .wr_o(wr_o), .push_o(push_o), .pc_load_o(pc_load_o),
        .pc_new_o(pc_new_o), .nop_o(nop_o));

    // ****************************************************************
    // clock, cycle count and hang guard
    // ****************************************************************
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    // ceiling well above the ~700 cycles the program needs
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ****************************************************************
    // comparison helpers
    // ****************************************************************
    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // an output with no note left is a mismatch: compare against its inverse
    task automatic pop_cmp(ref logic [95:0] q[$], input logic [95:0] got);
        if (q.size() == 0) check(got, ~got);
        else check(got, q.pop_front());
    endtask
    task automatic cmp_wr();
        pop_cmp(q_wr, {32'(cyc), 44'h0, wr_o.addr, wr_o.data});
    endtask
    task automatic cmp_push();
        pop_cmp(q_push, {32'(cyc), 20'h0, push_o.push, pc_load_o, push_o.addr, pc_new_o});
    endtask
    task automatic cmp_nop();
        pop_cmp(q_nop, {32'(cyc), 64'h1});
    endtask
    task automatic cmp_rd();
        pop_cmp(q_rd, {32'(cyc), 52'h0, rd_addr_o});
    endtask

    // ****************************************************************
    // monitor: results are looked at mid-cycle, when settled
    // ****************************************************************
    always @(negedge core_clk_i) begin
        if (!srst_i) begin
            if (wr_o.we) cmp_wr();
            if (push_o.push || pc_load_o) cmp_push();
            if (nop_o) cmp_nop();
            if (q_rd.size() != 0 && q_rd[0][95:64] == 32'(cyc)) cmp_rd();
        end
    end

    // ****************************************************************
    // drivers
    // ****************************************************************
    // one fetched word; a dropped word must come back as a no-op pulse
    task automatic put_word(input logic [15:0] w, input logic [7:0] rd, input logic [11:0] ptr,
                            input bit drop, output int k);
        @(posedge core_clk_i);
        #1;
        instr_valid_i = 1'b1;
        instr_i = w;
        rd_data_i = rd;
        second_indirect_pointer_i = ptr;
        working_register_i = 8'($random(seed));
        bank_select_register_i = 4'($random(seed));
        counter_high_latch_i = 8'($random(seed));
        counter_upper_latch_i = 5'($random(seed));
        pc_i = 21'($random(seed));
        k = cyc;
        if (drop) q_nop.push_back({32'(k + 1), 64'h1});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************************
    // main sequence: random program of all four kinds plus fillers
    // ****************************************************************
    initial begin
        int k, k2, kind;
        bit skip, drop, force_other;
        logic [2:0] b;
        logic a;
        logic [7:0] f, rd;
        logic [6:0] off;
        logic [11:0] ptr, src, dest, addr;
        {srst_i, instr_valid_i, instr_i, rd_data_i, working_register_i} = '0;
        {bank_select_register_i, second_indirect_pointer_i, pc_i} = '0;
        {counter_high_latch_i, counter_upper_latch_i} = '0;
        srst_i = 1'b1;
        {skip, force_other} = 2'b00;
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check({30'h0, wr_o, push_o, pc_load_o, pc_new_o, nop_o}, 96'h0);
        @(posedge core_clk_i);
        #1 srst_i = 1'b0;
        for (int i = 0; i < 500; i++) begin
            kind = force_other ? 0 : $unsigned($random(seed)) % 5;
            drop = skip;
            {skip, force_other} = 2'b00;
            rd = 8'($random(seed));
            ptr = 12'($random(seed));
            case (kind)
                0: put_word({2'b01, 14'($random(seed))}, rd, ptr, drop, k);
                1, 2: begin
                    {b, a, f} = 12'($random(seed));
                    put_word({(kind == 1) ? bscm_pkg::OP_SKIP_CLR : bscm_pkg::OP_SKIP_SET,
                              b, a, f}, rd, ptr, drop, k);
                    addr = a ? {bank_select_register_i, f} : (f < bscm_pkg::ACCESS_SPLIT ?
                           {4'h0, f} : {bscm_pkg::ACCESS_HI_BANK, f});
                    if (!drop) q_rd.push_back({32'(k + 1), 52'h0, addr});
                    skip = !drop && (rd[b] == (kind == 2));
                end
                3: begin
                    put_word(bscm_pkg::OP_CALL_WORKING_REGISTER, rd, ptr, drop, k);
                    if (!drop) q_push.push_back({32'(k + 1), 20'h0, 2'b11, pc_i + bscm_pkg::PC_STEP,
                        counter_upper_latch_i, counter_high_latch_i, working_register_i});
                    {skip, force_other} = {!drop, !drop};
                end
                default: begin
                    if (ptr > 12'hF80) ptr = ptr - 12'h080;
                    off = 7'($random(seed));
                    // a quarter of the moves read from the indirect window
                    if ($random(seed) % 4 == 0) begin
                        ptr = 12'hFD0;
                        off = 7'h0B + 7'($unsigned($random(seed)) % 21);
                    end
                    src = ptr + 12'(off);
                    dest = 12'($random(seed));
                    if (dest inside {12'hFF9, 12'hFFD, 12'hFFE, 12'hFFF}) dest = 12'h000;
                    put_word({bscm_pkg::OP_MOVE_IDX, off}, rd, ptr, drop, k);
                    put_word({bscm_pkg::OP_SECOND_WORD, dest}, 8'($random(seed)), ptr, drop, k2);
                    if (!drop) begin
                        q_rd.push_back({32'(k + 1), 52'h0, src});
                        q_wr.push_back({32'(k2 + 1), 44'h0, dest, (src >= bscm_pkg::ADDR_IND_LO &&
                            src <= bscm_pkg::ADDR_IND_HI) ? bscm_pkg::READ_ZERO : rd});
                    end
                end
            endcase
            // idle gaps only where no word is owed to a no-op
            if (!skip && $random(seed) % 3 == 0) begin
                @(posedge core_clk_i);
                #1 instr_valid_i = 1'b0;
            end
        end
        @(posedge core_clk_i);
        #1 instr_valid_i = 1'b0;
        repeat (4) @(posedge core_clk_i);
        check(96'(q_wr.size() + q_push.size() + q_nop.size() + q_rd.size()), 96'h0);
        tally_and_finish();
    end
endmodule // bit_skip_call_move_exec_bench
